/* rtl/sodc_map.svh */
// Register offsets, field positions, codes and reset values of the output drive control
`ifndef SODC_MAP_SVH
`define SODC_MAP_SVH
`define SODC_ADDR_W 7
`define SODC_OFS_RESET_CTRL 7'h00
`define SODC_OFS_HANDSHAKE 7'h01
`define SODC_OFS_SERIAL_RST_EN 7'h02
`define SODC_RST_CODE 8'hc3
`define SODC_SEL_LSB 1
`define SODC_SEL_MSB 3
`define SODC_REL_BIT 0
`define SODC_RSTEN_BIT 0
`define SODC_SEL_DRDY_SEL_ONLY 3'h0
`define SODC_SEL_DRDY_ALWAYS 3'h3
`define SODC_SEL_HIZ 3'h4
`define SODC_HANDSHAKE_RST 8'h00
`define SODC_SERIAL_RST_EN_RST 8'h00
`define SODC_BITS_PER_BYTE_M1 3'h7
`define SODC_MIN_BYTES_M1 2'h1
`endif

/* rtl/sodc_output_drive_ctrl.sv */
// Output drive control for the shared serial data-out / data-ready pin
`timescale 1ns/100ps
`include "sodc_map.svh"
module sodc_output_drive_ctrl
    import sodc_pkg::*;
(
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic sclk,
    input wire logic chip_select_n,
    input wire logic conv_read,
    input wire logic last_byte,
    input wire logic serial_data,
    input wire logic data_ready_n,
    input wire logic reg_wr_en,
    input wire logic reg_rd_en,
    input wire logic [`SODC_ADDR_W-1:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    output logic sdo_out,
    output logic sdo_oe,
    output logic serial_reset_armed,
    output logic reg_conv_reset
);
    typedef struct packed {
        logic [7:0] handshake;
        logic [7:0] rst_enable;
        logic rst_sticky;
        sodc_frame_e frame;
        logic [2:0] bit_cnt;
        logic [1:0] byte_cnt;
        logic pin_val;
        logic pin_oe;
        logic rst_pulse;
        logic [7:0] rdata;
    } sodc_state_s;

    sodc_state_s st_ff;
    sodc_state_s nxt_st;
    // Raw pins reach the logic only through the synchroniser
    sodc_pin_if pins ();

    sodc_pin_sampler sodc_pin_sampler_i (
        .ref_clk(ref_clk),
        .reset_n(reset_n),
        .sclk(sclk),
        .chip_select_n(chip_select_n),
        .pins(pins)
    );

    // Unmapped and write-only offsets read as zero
    function automatic logic [7:0] read_reg(input logic [`SODC_ADDR_W-1:0] addr,
                                            input sodc_state_s s);
        logic [7:0] val;
        val = 8'h00;
        if (addr == `SODC_OFS_HANDSHAKE) begin
            val = s.handshake;
        end else if (addr == `SODC_OFS_SERIAL_RST_EN) begin
            val = s.rst_enable;
        end
        return val;
    endfunction : read_reg

    // Data-ready may own the pin while selected under either drive code
    function automatic logic drdy_when_selected(input logic [2:0] sel);
        return sel == `SODC_SEL_DRDY_SEL_ONLY || sel == `SODC_SEL_DRDY_ALWAYS;
    endfunction : drdy_when_selected

    // Only one code keeps data-ready on the pin after deselect
    function automatic logic drdy_when_idle(input logic [2:0] sel);
        return sel == `SODC_SEL_DRDY_ALWAYS;
    endfunction : drdy_when_idle

    // Returns {enable, value}; forbidden codes drive read data only, else fall through to high-Z
    function automatic logic [1:0] pin_drive(input logic selected,
                                             input logic released,
                                             input logic reading,
                                             input logic [2:0] sel,
                                             input logic dout,
                                             input logic ready_n);
        logic [1:0] oe_val;
        oe_val = 2'h0;
        if (selected) begin
            // Released frame stays off the line until deselect
            if (released) begin
                oe_val = 2'h0;
            end else if (reading) begin
                oe_val = {1'b1, dout};
            end else if (drdy_when_selected(sel)) begin
                oe_val = {1'b1, ready_n};
            end
        end else if (drdy_when_idle(sel)) begin
            oe_val = {1'b1, ready_n};
        end
        return oe_val;
    endfunction : pin_drive

    // Release tracking; a cut frame restarts at the next select
    function automatic sodc_frame_e frame_next(input sodc_frame_e frame,
                                               input logic rise_last,
                                               input logic fall,
                                               input logic hold_to_fall);
        sodc_frame_e nxt;
        nxt = frame;
        unique case (frame)
            SODC_DRIVE: begin
                if (rise_last) begin
                    nxt = hold_to_fall ? SODC_HOLD_LAST : SODC_RELEASED;
                end
            end
            SODC_HOLD_LAST: begin
                if (fall) begin
                    nxt = SODC_RELEASED;
                end
            end
            SODC_RELEASED: begin
                nxt = SODC_RELEASED;
            end
            default: begin
                // Unused code; fall back to driving
                nxt = SODC_DRIVE;
            end
        endcase
        return nxt;
    endfunction : frame_next

    // Register writes; a write of the reset code restores both registers and clears the sticky flag
    function automatic sodc_state_s apply_write(input sodc_state_s s,
                                                input logic [`SODC_ADDR_W-1:0] addr,
                                                input logic [7:0] data);
        sodc_state_s r;
        r = s;
        // Any other value at the reset offset is ignored
        if (addr == `SODC_OFS_HANDSHAKE) begin
            // Forbidden codes are stored as written; behaviour then is read data while selected, high-Z otherwise
            r.handshake = data;
        end else if (addr == `SODC_OFS_SERIAL_RST_EN && !s.rst_sticky) begin
            // Sticky until the reset code clears it
            r.rst_enable = data;
            r.rst_sticky = 1'b1;
        end else if (addr == `SODC_OFS_RESET_CTRL && data == `SODC_RST_CODE) begin
            r.handshake = `SODC_HANDSHAKE_RST;
            r.rst_enable = `SODC_SERIAL_RST_EN_RST;
            r.rst_sticky = 1'b0;
            r.rst_pulse = 1'b1;
        end
        return r;
    endfunction : apply_write

    logic [2:0] drv_sel;
    logic rel_on_fall;
    logic last_rise;
    assign drv_sel = st_ff.handshake[`SODC_SEL_MSB:`SODC_SEL_LSB];
    assign rel_on_fall = st_ff.handshake[`SODC_REL_BIT];
    // Sixteenth bit or later, on a byte boundary, of the final byte
    assign last_rise = pins.sclk_rise && last_byte
                       && st_ff.bit_cnt == `SODC_BITS_PER_BYTE_M1
                       && st_ff.byte_cnt >= `SODC_MIN_BYTES_M1;

    always_comb begin
        nxt_st = st_ff;
        nxt_st.rst_pulse = 1'b0;
        // Read data holds until the next read strobe
        if (reg_rd_en) begin
            nxt_st.rdata = read_reg(reg_addr, st_ff);
        end

        // Frame tracking: counts restart on every deselect
        if (!pins.selected) begin
            nxt_st.frame = SODC_DRIVE;
            nxt_st.bit_cnt = 3'h0;
            nxt_st.byte_cnt = 2'h0;
        end else begin
            if (pins.sclk_rise) begin
                nxt_st.bit_cnt = st_ff.bit_cnt + 3'h1;
                if (st_ff.bit_cnt == `SODC_BITS_PER_BYTE_M1 && st_ff.byte_cnt != 2'h3) begin
                    nxt_st.byte_cnt = st_ff.byte_cnt + 2'h1;
                end
            end
            // Release tracking per frame
            nxt_st.frame = frame_next(st_ff.frame, last_rise, pins.sclk_fall, rel_on_fall);
        end

        // Pin source; released frames hand the line back to the host
        {nxt_st.pin_oe, nxt_st.pin_val} = pin_drive(pins.selected,
                                                    nxt_st.frame == SODC_RELEASED,
                                                    conv_read, drv_sel, serial_data,
                                                    data_ready_n);

        if (reg_wr_en) begin
            nxt_st = apply_write(nxt_st, reg_addr, reg_wdata);
        end
    end

    // Async reset leaves the line released and the reset function disarmed
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            st_ff <= '{handshake: `SODC_HANDSHAKE_RST, rst_enable: `SODC_SERIAL_RST_EN_RST,
                       rst_sticky: 1'b0, frame: SODC_DRIVE, bit_cnt: 3'h0, byte_cnt: 2'h0,
                       pin_val: 1'b0, pin_oe: 1'b0, rst_pulse: 1'b0, rdata: 8'h00};
        end else begin
            st_ff <= nxt_st;
        end
    end

    // Every output comes straight from a flop
    assign reg_rdata = st_ff.rdata;
    assign sdo_out = st_ff.pin_val;
    assign sdo_oe = st_ff.pin_oe;
    assign serial_reset_armed = st_ff.rst_enable[`SODC_RSTEN_BIT];
    assign reg_conv_reset = st_ff.rst_pulse;
endmodule : sodc_output_drive_ctrl

/* rtl/sodc_pin_if.sv */
// Synchronised serial-pin events passed from the sampler to the control logic
`timescale 1ns/100ps
interface sodc_pin_if;
    logic sclk_rise;
    logic sclk_fall;
    logic selected;
    modport sampler (output sclk_rise, output sclk_fall, output selected);
    modport ctrl (input sclk_rise, input sclk_fall, input selected);
endinterface : sodc_pin_if

/* rtl/sodc_pin_sampler.sv */
// Two-stage synchronisers for the serial clock and chip select, edge detection for the serial clock only
`timescale 1ns/100ps
module sodc_pin_sampler (
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic sclk,
    input wire logic chip_select_n,
    sodc_pin_if.sampler pins
);
    typedef struct packed {
        logic [1:0] sclk_meta;
        logic [1:0] cs_meta;
        logic sclk_prev;
    } sodc_smp_s;

    sodc_smp_s st_ff;
    sodc_smp_s nxt_st;

    always_comb begin
        nxt_st = st_ff;
        nxt_st.sclk_meta = {st_ff.sclk_meta[0], sclk};
        nxt_st.cs_meta = {st_ff.cs_meta[0], chip_select_n};
        nxt_st.sclk_prev = st_ff.sclk_meta[1];
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            st_ff <= '{sclk_meta: 2'h0, cs_meta: 2'h3, sclk_prev: 1'b0};
        end else begin
            st_ff <= nxt_st;
        end
    end

    // Only the second stage is looked at
    assign pins.sclk_rise = st_ff.sclk_meta[1] & ~st_ff.sclk_prev;
    assign pins.sclk_fall = ~st_ff.sclk_meta[1] & st_ff.sclk_prev;
    assign pins.selected = ~st_ff.cs_meta[1];
endmodule : sodc_pin_sampler

/* rtl/sodc_pkg.sv */
// Types shared by the output drive control modules
package sodc_pkg;
    typedef enum logic [1:0] {
        SODC_DRIVE = 2'h0,
        SODC_HOLD_LAST = 2'h1,
        SODC_RELEASED = 2'h3
    } sodc_frame_e;
endpackage : sodc_pkg

/* tb/sodc_host_model.sv */
// Host-side serial model: drives serial clock and chip select
`timescale 1ns/100ps
module sodc_host_model #(parameter int HALF = 10) (
    input wire logic ref_clk,
    output logic sclk,
    output logic chip_select_n
);
    // Clock stands still low outside frames
    initial begin
        sclk = 1'b0;
        chip_select_n = 1'b1;
    end
    task automatic sel(input logic v);
        @(negedge ref_clk);
        chip_select_n = v;
        repeat (HALF) @(negedge ref_clk);
    endtask : sel
    task automatic clk(input logic v);
        @(negedge ref_clk);
        sclk = v;
        repeat (HALF) @(negedge ref_clk);
    endtask : clk
endmodule : sodc_host_model

/* tb/sodc_output_drive_ctrl_properties.sv */
// Port-level assertions for the output drive control
`timescale 1ns/100ps
module sodc_output_drive_ctrl_properties (
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic chip_select_n,
    input wire logic conv_read,
    input wire logic last_byte,
    input wire logic reg_wr_en,
    input wire logic reg_rd_en,
    input wire logic [6:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata,
    input wire logic sdo_oe,
    input wire logic serial_reset_armed,
    input wire logic reg_conv_reset
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!reset_n);
    wire rst_wr = reg_wr_en && reg_addr == 7'h00 && reg_wdata == 8'hc3;
    wire en_wr = reg_wr_en && reg_addr == 7'h02 && reg_wdata[0];
    wire hs_rd = reg_rd_en && !reg_wr_en && reg_addr == 7'h01;
    rst_pulse_a: assert property (rst_wr |=> reg_conv_reset)
        else $error("reset pulse missing");
    no_pulse_a: assert property (!rst_wr |=> !reg_conv_reset)
        else $error("unexpected reset pulse");
    arm_cause_a: assert property ($rose(serial_reset_armed) |-> $past(en_wr))
        else $error("armed without write");
    arm_sticky_a: assert property (serial_reset_armed && !rst_wr |=> serial_reset_armed)
        else $error("armed lost");
    arm_clear_a: assert property (reg_conv_reset |=> !serial_reset_armed)
        else $error("armed kept over reset");
    hs_back_a: assert property (reg_wr_en && reg_addr == 7'h01 ##1 !reg_wr_en ##1 hs_rd
        && !reg_conv_reset |=> reg_rdata == $past(reg_wdata, 3))
        else $error("handshake readback");
    hs_clear_a: assert property (reg_conv_reset ##1 hs_rd |=> reg_rdata == 8'h00)
        else $error("handshake kept over reset");
    frame_rel_a: assert property ($fell(sdo_oe) && conv_read && !chip_select_n
        && !$past(chip_select_n, 8) |-> last_byte)
        else $error("early release");
endmodule : sodc_output_drive_ctrl_properties
bind sodc_output_drive_ctrl sodc_output_drive_ctrl_properties sodc_output_drive_ctrl_properties_i (
    .ref_clk(ref_clk), .reset_n(reset_n), .chip_select_n(chip_select_n),
    .conv_read(conv_read), .last_byte(last_byte), .reg_wr_en(reg_wr_en),
    .reg_rd_en(reg_rd_en), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .sdo_oe(sdo_oe), .serial_reset_armed(serial_reset_armed),
    .reg_conv_reset(reg_conv_reset));

/* tb/tb_top.sv */
// Self-checking bench for the output drive control
`timescale 1ns/100ps
module tb_top;
    logic ref_clk = 0, reset_n = 0, conv_read = 0, last_byte = 0, serial_data = 0;
    logic data_ready_n = 0, reg_wr_en = 0, reg_rd_en = 0;
    logic [6:0] reg_addr = 0;
    logic [7:0] reg_wdata = 0;
    logic [7:0] reg_rdata;
    logic sclk, chip_select_n, sdo_out, sdo_oe, serial_reset_armed, reg_conv_reset;
    int n_mismatch = 0, n_checks = 0, cyc = 0;
    sodc_host_model sodc_host_model_i (.ref_clk(ref_clk), .sclk(sclk),
                                       .chip_select_n(chip_select_n));
    sodc_output_drive_ctrl sodc_output_drive_ctrl_i (
        .ref_clk(ref_clk), .reset_n(reset_n), .sclk(sclk), .chip_select_n(chip_select_n),
        .conv_read(conv_read), .last_byte(last_byte), .serial_data(serial_data),
        .data_ready_n(data_ready_n), .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .sdo_out(sdo_out), .sdo_oe(sdo_oe), .serial_reset_armed(serial_reset_armed),
        .reg_conv_reset(reg_conv_reset)
    );
    initial forever #4 ref_clk = ~ref_clk;
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : wrap_up
    // Long enough for all frames at the slow host rate
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 8000) begin
            n_mismatch++;
            wrap_up();
        end
    end
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        @(negedge ref_clk);
        reg_addr = a;
        reg_wdata = d;
        reg_wr_en = 1;
        @(negedge ref_clk);
        reg_wr_en = 0;
    endtask : wr
    task automatic rdc(input logic [6:0] a, input logic [7:0] exp);
        @(negedge ref_clk);
        reg_addr = a;
        reg_rd_en = 1;
        @(negedge ref_clk);
        reg_rd_en = 0;
        chk("rdata", exp, reg_rdata);
    endtask : rdc
    task automatic t_sticky();
        rdc(7'h02, 8'h00);
        rdc(7'h05, 8'h00);
        wr(7'h02, 8'h01);
        chk("armed", 8'h01, {7'h0, serial_reset_armed});
        wr(7'h02, 8'h00);
        rdc(7'h02, 8'h01);
        wr(7'h01, 8'h06);
        wr(7'h00, 8'h55);
        chk("pulse", 8'h00, {7'h0, reg_conv_reset});
        rdc(7'h01, 8'h06);
        wr(7'h00, 8'hc3);
        chk("pulse", 8'h01, {7'h0, reg_conv_reset});
        rdc(7'h01, 8'h00);
        chk("armed", 8'h00, {7'h0, serial_reset_armed});
        wr(7'h02, 8'h01);
        rdc(7'h02, 8'h01);
        $display("test sticky done");
    endtask : t_sticky
    task automatic t_mode(input logic [2:0] code, input logic oe_sel, input logic oe_idle);
        data_ready_n = code[0];
        wr(7'h01, {4'h0, code, 1'b0});
        rdc(7'h01, {4'h0, code, 1'b0});
        sodc_host_model_i.sel(0);
        chk("oe_sel", {7'h0, oe_sel}, {7'h0, sdo_oe});
        if (oe_sel) chk("out_sel", {7'h0, data_ready_n}, {7'h0, sdo_out});
        sodc_host_model_i.sel(1);
        chk("oe_idle", {7'h0, oe_idle}, {7'h0, sdo_oe});
        $display("test mode %h done", code);
    endtask : t_mode
    task automatic t_frame(input logic rel);
        wr(7'h01, {7'h0, rel});
        conv_read = 1;
        serial_data = ~data_ready_n;
        sodc_host_model_i.sel(0);
        for (int i = 1; i <= 16; i++) begin
            last_byte = (i > 8);
            sodc_host_model_i.clk(1);
            if (i == 8) chk("sdo", {7'h0, serial_data}, {7'h0, sdo_out});
            if (i == 16) chk("oe_last", {7'h0, rel}, {7'h0, sdo_oe});
            sodc_host_model_i.clk(0);
        end
        chk("oe_end", 8'h00, {7'h0, sdo_oe});
        sodc_host_model_i.sel(1);
        conv_read = 0;
        last_byte = 0;
        $display("test frame %0d done", rel);
    endtask : t_frame
    initial begin
        repeat (10) @(negedge ref_clk);
        reset_n = 1;
        t_sticky();
        t_mode(3'h0, 1'b1, 1'b0);
        t_mode(3'h3, 1'b1, 1'b1);
        t_mode(3'h4, 1'b0, 1'b0);
        t_frame(1'b0);
        t_frame(1'b1);
        wrap_up();
    end
endmodule : tb_top
